// [pkg/hdlc_irq_regs.vh]
`ifndef HDLC_IRQ_REGS_VH
`define HDLC_IRQ_REGS_VH
// Byte offsets of the register map
`define TOP_STATUS_OFS 8'h00
`define TOP_MASK_OFS 8'h04
`define DPRI_OFS 8'h08
`define DMASK_OFS 8'h0c
`define DEXT_OFS 8'h10
`define CIR_OFS 8'h14
`define DCMD_OFS 8'h18
`define DMODE_OFS 8'h1c
`define BCH_BASE 8'h40
`define BCH_STRIDE 8'h20
`define B_PRI_OFS 8'h00
`define B_MASK_OFS 8'h04
`define B_EXT_OFS 8'h08
`define B_CFG_OFS 8'h0c
`define B_CMD_OFS 8'h10
`define B_INFO_OFS 8'h14
// Top-level status bit positions
`define TOP_IDC 5
`define TOP_EXD 4
`define TOP_ICA 3
`define TOP_EXA 2
`define TOP_ICB 1
`define TOP_EXB 0
// Primary status bits, both channel kinds
`define PRI_RME 7
`define PRI_RPF 6
`define PRI_RSC 5
`define PRI_XPR 4
`define PRI_TIN 3
`define PRI_CIC 2
`define PRI_TIN2 1
// Extended status bits
`define EXT_XMR 7
`define EXT_XDU 6
`define EXT_PCE 5
`define EXT_RFO 4
`define EXT_RFS 3
// Config and command bits
`define CFG_RIE 0
`define CFG_ADDR_MODE 1
`define CMD_TRANSMITTER_RESET_CMD 0
`define CMD_XTF 1
`define CMD_XME 2
`define DCMD_RMC 0
`define DMODE_AUTO 0
// Reset values
`define TOP_MASK_RST 8'h00
`define MASK_RST 8'h00
`define CFG_RST 8'h00
// Sizes and counts
`define B_POOL_BYTES 7'h40
`define RFS_DELAY_BYTES 2'h2
`define D_POOLS 2'h2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [logic/hdlc_channel_interrupt_status.v]
// Function
// - B-channel primary flag with its mask bit set raises no interrupt
// - B receive-pool-full sets when 64 bytes held and frame still open
// - B receive-message-end sets after CRC and closing flag of frame end
// - B receive-overflow sets when FIFO full and new frame starts
// - B receive-frame-start only raised while its enable bit is set
// - Frame-start after address check, or two bytes after opening flag
// - Header, address and status low bits held valid after frame-start
// - B transmit-pool-ready on empty pool or transmitter reset, not on transparent transfer
// - After end-of-message, pool-ready once frame fully shifted out
// - B transmit-repeat flag set when last frame must be resent
// - B transmit underrun when FIFO drained without end-of-message
// - Reading D primary clears all unmasked bits but C/I change; C/I read clears that
// - Reading D extended clears it and its top-level indication
// - Masked D events stay pending, hidden from reads except C/I change, appear when unmasked
// - Masked D-extended indication neither sets nor interrupts
// - C/I change sets while masked but raises no interrupt
// - D receive storage is two 32-byte pools under FIFO control
// - Host reads 32 octets on pool-full then issues receive-memory-clear
// - Host reads byte count and status on message-end, then memory-clear
// - D receive-overflow when a whole frame is lost for lack of space
// - D protocol-error flagged only in automatic mode
// - All D causes, C/I change included, shown in D status registers
// - Interrupt output low until all unmasked pending sources cleared
// - Top-level bits 5-0 point at D, A and B primary and extended
// - Clearing a lower-level source clears its top-level indication
`include "hdlc_irq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module hdlc_channel_interrupt_status #(
  parameter NUM_BCH = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [7*NUM_BCH-1:0] b_rx_level,
  input wire [NUM_BCH-1:0] b_rx_frame_end,
  input wire [NUM_BCH-1:0] b_rx_frame_begin,
  input wire [NUM_BCH-1:0] b_rx_addr_ok,
  input wire [NUM_BCH-1:0] b_rx_open_flag,
  input wire [NUM_BCH-1:0] b_rx_byte,
  input wire [8*NUM_BCH-1:0] b_rx_header,
  input wire [8*NUM_BCH-1:0] b_rx_addr,
  input wire [4*NUM_BCH-1:0] b_rx_status,
  input wire [NUM_BCH-1:0] b_tx_pool_empty,
  input wire [NUM_BCH-1:0] b_tx_frame_done,
  input wire [NUM_BCH-1:0] b_tx_repeat,
  input wire [NUM_BCH-1:0] b_tx_fifo_drained,
  input wire d_rx_pool_filled,
  input wire d_rx_frame_end,
  input wire d_rx_frame_begin,
  input wire [7:0] d_pri_event,
  input wire [7:0] d_ext_event,
  input wire d_nr_error,
  input wire d_ci_change,
  output reg [NUM_BCH-1:0] b_tx_reset,
  output reg [NUM_BCH-1:0] b_tx_transparent,
  output reg [NUM_BCH-1:0] b_tx_msg_end,
  output reg d_rx_pool_release,
  output reg irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  reg aw_got_r;
  reg w_got_r;
  reg [7:0] waddr_r;
  reg [7:0] wbyte_r;
  reg wlane_r;
  wire wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
  wire rd_go = s_axi_arvalid && s_axi_arready;
  wire [7:0] raddr = s_axi_araddr;
  wire wr_mapped;
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a[7:2] == ofs[7:2]);
    end
  endfunction
  function bch_hit;
    input [7:0] a;
    input integer ch;
    input [7:0] ofs;
    reg [7:0] base;
    begin
      base = `BCH_BASE + ch[2:0] * `BCH_STRIDE + ofs;
      bch_hit = hit(a, base);
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= 8'h00;
      wbyte_r <= 8'h00;
      wlane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_got_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  wire wr_en = wr_go && wlane_r;
  ////////////////////////////////////////////////////////////////////////////
  // B channels
  wire [8*NUM_BCH-1:0] bpri_all;
  wire [8*NUM_BCH-1:0] bmask_all;
  wire [8*NUM_BCH-1:0] bext_all;
  wire [8*NUM_BCH-1:0] bcfg_all;
  wire [32*NUM_BCH-1:0] binfo_all;
  wire [NUM_BCH-1:0] bmap_w;
  wire [NUM_BCH-1:0] bmap_r;

  genvar g;
  generate
    for (g = 0; g < NUM_BCH; g = g + 1) begin : bch
      reg [7:0] pri_r;
      reg [7:0] mask_r;
      reg [7:0] ext_r;
      reg [7:0] cfg_r;
      reg [6:0] lvl_prev_r;
      reg [1:0] flag_cnt_r;
      reg flag_run_r;
      reg xme_r;
      reg [7:0] hdr_r;
      reg [7:0] adr_r;
      reg [3:0] sta_r;
      wire [6:0] lvl = b_rx_level[7*g +: 7];
      wire fend = b_rx_frame_end[g];
      wire cmd_wr = wr_en && bch_hit(waddr_r, g, `B_CMD_OFS);
      wire transmitter_reset_cmd = cmd_wr && wbyte_r[`CMD_TRANSMITTER_RESET_CMD];
      wire end_of_message_cmd = cmd_wr && wbyte_r[`CMD_XME];
      wire start_seen = cfg_r[`CFG_ADDR_MODE] ? b_rx_addr_ok[g] :
                        (flag_run_r && b_rx_byte[g] && flag_cnt_r == `RFS_DELAY_BYTES - 2'h1);
      wire receive_frame_start = start_seen && cfg_r[`CFG_RIE];
      reg [7:0] pset;
      reg [7:0] eset;
      always @* begin
        pset = 8'h00;
        eset = 8'h00;
        pset[`PRI_RPF] = lvl == `B_POOL_BYTES && lvl_prev_r != `B_POOL_BYTES && !fend;
        pset[`PRI_RME] = fend;
        pset[`PRI_XPR] = b_tx_pool_empty[g] || transmitter_reset_cmd || (b_tx_frame_done[g] && xme_r);
        eset[`EXT_RFO] = lvl == `B_POOL_BYTES && b_rx_frame_begin[g];
        eset[`EXT_RFS] = receive_frame_start;
        eset[`EXT_XMR] = b_tx_repeat[g];
        eset[`EXT_XDU] = b_tx_fifo_drained[g] && !xme_r;
      end
      wire pclr = rd_go && bch_hit(raddr, g, `B_PRI_OFS);
      wire eclr = rd_go && bch_hit(raddr, g, `B_EXT_OFS);
      always @(posedge aclk) begin
        if (!aresetn) begin
          pri_r <= 8'h00;
          ext_r <= 8'h00;
          mask_r <= `MASK_RST;
          cfg_r <= `CFG_RST;
          lvl_prev_r <= 7'h00;
          flag_cnt_r <= 2'h0;
          flag_run_r <= 1'b0;
          xme_r <= 1'b0;
          hdr_r <= 8'h00;
          adr_r <= 8'h00;
          sta_r <= 4'h0;
        end else begin
          // Sets win over a clearing read in the same cycle
          pri_r <= (pclr ? 8'h00 : pri_r) | pset;
          ext_r <= (eclr ? 8'h00 : ext_r) | eset;
          lvl_prev_r <= lvl;
          if (wr_en && bch_hit(waddr_r, g, `B_MASK_OFS))
            mask_r <= wbyte_r;
          if (wr_en && bch_hit(waddr_r, g, `B_CFG_OFS))
            cfg_r <= wbyte_r;
          if (b_rx_open_flag[g]) begin
            flag_run_r <= 1'b1;
            flag_cnt_r <= 2'h0;
          end else if (flag_run_r && b_rx_byte[g]) begin
            flag_cnt_r <= flag_cnt_r + 2'h1;
            if (flag_cnt_r == `RFS_DELAY_BYTES - 2'h1)
              flag_run_r <= 1'b0;
          end
          if (transmitter_reset_cmd || b_tx_frame_done[g])
            xme_r <= 1'b0;
          else if (end_of_message_cmd)
            xme_r <= 1'b1;
          if (start_seen) begin
            hdr_r <= b_rx_header[8*g +: 8];
            adr_r <= b_rx_addr[8*g +: 8];
            sta_r <= b_rx_status[4*g +: 4];
          end
        end
      end
      assign bpri_all[8*g +: 8] = pri_r;
      assign bmask_all[8*g +: 8] = mask_r;
      assign bext_all[8*g +: 8] = ext_r;
      assign bcfg_all[8*g +: 8] = cfg_r;
      assign binfo_all[32*g +: 32] = {12'h000, sta_r, adr_r, hdr_r};
      assign bmap_w[g] = bch_hit(waddr_r, g, `B_MASK_OFS) || bch_hit(waddr_r, g, `B_CFG_OFS) ||
                         bch_hit(waddr_r, g, `B_CMD_OFS);
      assign bmap_r[g] = bch_hit(raddr, g, `B_PRI_OFS) || bch_hit(raddr, g, `B_MASK_OFS) ||
                         bch_hit(raddr, g, `B_EXT_OFS) || bch_hit(raddr, g, `B_CFG_OFS) ||
                         bch_hit(raddr, g, `B_INFO_OFS);
      always @(posedge aclk) begin
        if (!aresetn) begin
          b_tx_reset[g] <= 1'b0;
          b_tx_transparent[g] <= 1'b0;
          b_tx_msg_end[g] <= 1'b0;
        end else begin
          b_tx_reset[g] <= transmitter_reset_cmd;
          b_tx_transparent[g] <= cmd_wr && wbyte_r[`CMD_XTF];
          b_tx_msg_end[g] <= end_of_message_cmd;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // D channel
  reg [7:0] dpend_r;
  reg [7:0] dmask_r;
  reg [7:0] dext_r;
  reg [7:0] top_mask_r;
  reg [7:0] dmode_r;
  reg [1:0] pools_used_r;
  wire pool_free = pools_used_r != `D_POOLS;
  wire receive_memory_clear_cmd = wr_en && hit(waddr_r, `DCMD_OFS) && wbyte_r[`DCMD_RMC];
  wire dpri_rd = rd_go && hit(raddr, `DPRI_OFS);
  wire dext_rd = rd_go && hit(raddr, `DEXT_OFS);
  wire cir_rd = rd_go && hit(raddr, `CIR_OFS);
  wire [7:0] dvis = dpend_r & ~dmask_r;
  wire [7:0] dshow = dvis | (dpend_r & (8'h01 << `PRI_CIC));
  reg [7:0] dset;
  reg [7:0] dxset;
  reg [7:0] dclr;
  reg [1:0] pools_nxt;
  always @* begin
    dset = d_pri_event & ~((8'h01 << `PRI_RME) | (8'h01 << `PRI_RPF) | (8'h01 << `PRI_CIC));
    dset[`PRI_RPF] = d_rx_pool_filled && pool_free;
    dset[`PRI_RME] = d_rx_frame_end && pool_free;
    dset[`PRI_CIC] = d_ci_change;
    dxset = d_ext_event & ~((8'h01 << `EXT_PCE) | (8'h01 << `EXT_RFO));
    dxset[`EXT_PCE] = d_nr_error && dmode_r[`DMODE_AUTO];
    dxset[`EXT_RFO] = d_rx_frame_begin && !pool_free;
    // Primary read clears only unmasked bits, never the C/I change; C/I read clears that
    dclr = 8'h00;
    if (dpri_rd)
      dclr = dvis & ~(8'h01 << `PRI_CIC);
    if (cir_rd)
      dclr[`PRI_CIC] = 1'b1;
    pools_nxt = pools_used_r;
    if ((dset[`PRI_RPF] || dset[`PRI_RME]) && !receive_memory_clear_cmd)
      pools_nxt = pools_used_r + 2'h1;
    else if (receive_memory_clear_cmd && !(dset[`PRI_RPF] || dset[`PRI_RME]) && pools_used_r != 2'h0)
      pools_nxt = pools_used_r - 2'h1;
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      dpend_r <= 8'h00;
      dext_r <= 8'h00;
      dmask_r <= `MASK_RST;
      top_mask_r <= `TOP_MASK_RST;
      dmode_r <= `CFG_RST;
      pools_used_r <= 2'h0;
      d_rx_pool_release <= 1'b0;
    end else begin
      dpend_r <= (dpend_r & ~dclr) | dset;
      dext_r <= (dext_rd ? 8'h00 : dext_r) | dxset;
      pools_used_r <= pools_nxt;
      d_rx_pool_release <= receive_memory_clear_cmd;
      if (wr_en && hit(waddr_r, `DMASK_OFS))
        dmask_r <= wbyte_r;
      if (wr_en && hit(waddr_r, `TOP_MASK_OFS))
        top_mask_r <= wbyte_r;
      if (wr_en && hit(waddr_r, `DMODE_OFS))
        dmode_r <= wbyte_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Top-level status and interrupt
  reg [7:0] top_stat;
  always @* begin
    top_stat = 8'h00;
    // Indications follow their sources, so clearing below clears here
    top_stat[`TOP_IDC] = |(dvis & ~(8'h01 << `PRI_CIC)) || (dvis[`PRI_CIC]);
    top_stat[`TOP_EXD] = |dext_r && !top_mask_r[`TOP_EXD];
    top_stat[`TOP_ICA] = |(bpri_all[7:0] & ~bmask_all[7:0]);
    top_stat[`TOP_EXA] = |bext_all[7:0];
    if (NUM_BCH > 1) begin
      top_stat[`TOP_ICB] = |(bpri_all[15:8] & ~bmask_all[15:8]);
      top_stat[`TOP_EXB] = |bext_all[15:8];
    end
  end
  wire irq_now = |(top_stat & ~top_mask_r);
  always @(posedge aclk) begin
    if (!aresetn)
      irq_n <= 1'b1;
    else
      irq_n <= !irq_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  assign wr_mapped = hit(waddr_r, `TOP_MASK_OFS) || hit(waddr_r, `DMASK_OFS) ||
                   hit(waddr_r, `DCMD_OFS) || hit(waddr_r, `DMODE_OFS) || |bmap_w;
  reg [31:0] rd_mux;
  reg rd_ok;
  integer i;
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    if (hit(raddr, `TOP_STATUS_OFS))
      rd_mux[7:0] = top_stat;
    else if (hit(raddr, `TOP_MASK_OFS))
      rd_mux[7:0] = top_mask_r;
    else if (hit(raddr, `DPRI_OFS))
      rd_mux[7:0] = dshow;
    else if (hit(raddr, `DMASK_OFS))
      rd_mux[7:0] = dmask_r;
    else if (hit(raddr, `DEXT_OFS))
      rd_mux[7:0] = dext_r;
    else if (hit(raddr, `CIR_OFS))
      rd_mux[`PRI_CIC] = dpend_r[`PRI_CIC];
    else if (hit(raddr, `DMODE_OFS))
      rd_mux[7:0] = dmode_r;
    else if (!(|bmap_r))
      rd_ok = 1'b0;
    for (i = 0; i < NUM_BCH; i = i + 1) begin
      if (bch_hit(raddr, i, `B_PRI_OFS))
        rd_mux[7:0] = bpri_all[8*i +: 8];
      if (bch_hit(raddr, i, `B_MASK_OFS))
        rd_mux[7:0] = bmask_all[8*i +: 8];
      if (bch_hit(raddr, i, `B_EXT_OFS))
        rd_mux[7:0] = bext_all[8*i +: 8];
      if (bch_hit(raddr, i, `B_CFG_OFS))
        rd_mux[7:0] = bcfg_all[8*i +: 8];
      if (bch_hit(raddr, i, `B_INFO_OFS))
        rd_mux = binfo_all[32*i +: 32];
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // hdlc_channel_interrupt_status
`default_nettype wire

// [verif/hdlc_irq_checker_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module hdlc_irq_checker #(
  parameter NUM_BCH = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [NUM_BCH-1:0] b_tx_reset,
  input wire logic [NUM_BCH-1:0] b_tx_transparent,
  input wire logic [NUM_BCH-1:0] b_tx_msg_end,
  input wire logic d_rx_pool_release,
  input wire logic irq_n
);
  logic rd_take_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Read accepted one edge ago
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_take_r <= 1'b0;
    end else begin
      rd_take_r <= s_axi_arvalid && s_axi_arready;
    end
  end
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after the take");
  a_release_pulse: assert property (d_rx_pool_release |=> !d_rx_pool_release)
    else $error("pool release longer than one cycle");
  a_release_cause: assert property (d_rx_pool_release |-> $rose(s_axi_bvalid))
    else $error("pool release without write response");
  a_txreset_cause: assert property (|b_tx_reset |-> $rose(s_axi_bvalid))
    else $error("transmitter reset without write response");
  a_msgend_cause: assert property (|b_tx_msg_end |-> $rose(s_axi_bvalid))
    else $error("message end without write response");
  a_transp_pulse: assert property (|b_tx_transparent |=> !(|b_tx_transparent))
    else $error("transparent command longer than one cycle");
  a_irq_release_cause: assert property ($rose(irq_n) |-> $past(rd_take_r) || $past(s_axi_bvalid))
    else $error("interrupt released without read or write");
  c_release: cover property (d_rx_pool_release);
  c_irq_low: cover property ($fell(irq_n));
  c_txreset: cover property (|b_tx_reset);
endmodule // hdlc_irq_checker
bind hdlc_channel_interrupt_status hdlc_irq_checker #(.NUM_BCH(NUM_BCH)) hdlc_irq_checker_inst (.*);
`default_nettype wire

// [verif/hdlc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module hdlc_host_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Payload inverted once taken so stale values never look valid
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic busy;
    busy = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (busy) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~s_axi_wdata;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic busy;
    busy = 1'b1;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (busy) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        busy = 1'b0;
      end
    end
  endtask
endmodule // hdlc_host_model
`default_nettype wire

// [verif/hdlc_channel_interrupt_status_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hdlc_irq_regs.vh"
module hdlc_channel_interrupt_status_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  wire [7:0] s_axi_awaddr, s_axi_araddr;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] b_rx_level = 14'h0000;
  logic [15:0] b_rx_header = 16'h5aa5;
  logic [15:0] b_rx_addr = 16'h3cc3;
  logic [7:0] b_rx_status = 8'h96;
  logic [38:0] ev = 39'h0;
  wire [1:0] b_rx_frame_end, b_rx_frame_begin, b_rx_addr_ok, b_rx_open_flag, b_rx_byte;
  wire [1:0] b_tx_pool_empty, b_tx_frame_done, b_tx_repeat, b_tx_fifo_drained;
  wire d_rx_pool_filled, d_rx_frame_end, d_rx_frame_begin, d_nr_error, d_ci_change;
  wire [7:0] d_pri_event, d_ext_event;
  wire [1:0] b_tx_reset, b_tx_transparent, b_tx_msg_end;
  wire d_rx_pool_release, irq_n;
  int mismatches = 0;
  int num_checks = 0;
  // All event pulses packed into one vector
  assign {d_ext_event, d_pri_event, d_ci_change, d_nr_error, d_rx_frame_begin, d_rx_frame_end,
    d_rx_pool_filled, b_tx_fifo_drained, b_tx_repeat, b_tx_frame_done, b_tx_pool_empty, b_rx_byte,
    b_rx_open_flag, b_rx_addr_ok, b_rx_frame_begin, b_rx_frame_end} = ev;
  hdlc_channel_interrupt_status #(.NUM_BCH(2)) hdlc_channel_interrupt_status_inst (.*);
  hdlc_host_model hdlc_host_model_inst (.*);
  always #50 aclk = ~aclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] rr;
    hdlc_host_model_inst.bus_wr(a, d, rr);
    chk({30'h0, rr}, {30'h0, `RESP_OKAY});
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] rr;
    hdlc_host_model_inst.bus_rd(a, d, rr);
    chk(d, e);
  endtask
  task automatic fire(input logic [38:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= 39'h0;
    @(posedge aclk);
  endtask
  task automatic irq(input logic e);
    @(posedge aclk);
    chk({31'h0, irq_n}, {31'h0, e});
  endtask
  ////////////////////////////////////////
  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] rr;
    irq(1'b1);
    hdlc_host_model_inst.bus_rd(8'h30, d, rr);
    chk(d, 32'h0);
    chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
    hdlc_host_model_inst.bus_wr(8'h00, 8'hff, rr);
    chk({30'h0, rr}, {30'h0, `RESP_SLVERR});
    r(8'h00, 32'h0);
    r(8'h0c, 32'h0);
  endtask
  task automatic t_bmask;
    r(8'h44, 32'h0);
    w(8'h44, 8'h80);
    fire(39'h1);
    irq(1'b1);
    r(8'h40, 32'h80);
    w(8'h44, 8'h00);
    fire(39'h1);
    irq(1'b0);
    r(8'h00, 32'h08);
    r(8'h40, 32'h80);
    r(8'h00, 32'h00);
    irq(1'b1);
    fire(39'h2);
    r(8'h00, 32'h02);
    r(8'h60, 32'h80);
  endtask
  task automatic t_brx;
    b_rx_level <= 14'h003f;
    fire(39'h0);
    r(8'h40, 32'h0);
    b_rx_level <= 14'h0040;
    fire(39'h4);
    b_rx_level <= 14'h0000;
    r(8'h40, 32'h40);
    r(8'h48, 32'h10);
  endtask
  task automatic t_rfs;
    fire(39'h40);
    repeat (2) fire(39'h100);
    r(8'h48, 32'h0);
    w(8'h4c, 8'h01);
    fire(39'h40);
    repeat (2) fire(39'h100);
    r(8'h48, 32'h08);
    r(8'h54, 32'h0006c3a5);
    w(8'h4c, 8'h03);
    fire(39'h10);
    r(8'h48, 32'h08);
    w(8'h4c, 8'h00);
  endtask
  task automatic t_btx;
    w(8'h50, 8'h01);
    w(8'h50, 8'h02);
    r(8'h40, 32'h10);
    fire(39'h400);
    r(8'h40, 32'h10);
    fire(39'h4000);
    r(8'h48, 32'h80);
    fire(39'h10000);
    r(8'h48, 32'h40);
    w(8'h50, 8'h04);
    fire(39'h1000);
    r(8'h40, 32'h10);
  endtask
  task automatic t_dpri;
    w(8'h0c, 8'h24);
    fire(39'h10000000);
    fire(39'h400000);
    irq(1'b1);
    r(8'h08, 32'h04);
    r(8'h08, 32'h04);
    r(8'h14, 32'h04);
    w(8'h0c, 8'h00);
    irq(1'b0);
    r(8'h08, 32'h20);
    r(8'h08, 32'h00);
    irq(1'b1);
  endtask
  task automatic t_dext;
    w(8'h04, 8'h10);
    fire(39'h4000000000);
    irq(1'b1);
    r(8'h00, 32'h00);
    r(8'h10, 32'h80);
    w(8'h04, 8'h00);
    fire(39'h200000);
    r(8'h10, 32'h00);
    w(8'h1c, 8'h01);
    fire(39'h200000);
    irq(1'b0);
    r(8'h00, 32'h10);
    r(8'h10, 32'h20);
    r(8'h00, 32'h00);
    irq(1'b1);
    w(8'h1c, 8'h00);
  endtask
  task automatic t_dpool;
    fire(39'h40000);
    r(8'h08, 32'h40);
    fire(39'h80000);
    r(8'h08, 32'h80);
    fire(39'h100000);
    fire(39'h40000);
    r(8'h08, 32'h00);
    r(8'h10, 32'h10);
    w(8'h18, 8'h01);
    fire(39'h80000);
    r(8'h08, 32'h80);
    w(8'h18, 8'h01);
    w(8'h18, 8'h01);
  endtask
  ////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_bus;
    t_bmask;
    t_brx;
    t_rfs;
    t_btx;
    t_dpri;
    t_dext;
    t_dpool;
    complete_run;
  end
  initial begin
    repeat (4000) @(posedge aclk);
    mismatches++;
    complete_run;
  end
endmodule // hdlc_channel_interrupt_status_tb_top
`default_nettype wire
